// ==== hw/spsr_core.sv ====
// Purpose: select handling, registers and byte engine of a serial port
// Assumes: core_clk 50 MHz; link pins are asynchronous and synchronised
// Notes:   registers are reached over avalon-mm, answer one cycle late
`timescale 1ns/1ps
`include "spsr_params.svh"

module spsr_core
    import spsr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [1:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [7:0] avs_writedata,
    output logic      [7:0] avs_readdata,
    output logic            avs_waitrequest,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe,
    input  wire logic       ss_n_in,
    output logic            ss_gpio,
    output logic            wired_or_mode,
    output logic            irq
);

    spsr_state_t st_ff;
    spsr_state_t nxt_st;

    // half-period of the serial clock in core clocks: twice the divisor
    // gives a full period, so baud = clk / (2 * divisor)
    function automatic logic [7:0] half_period(input logic [1:0] code);
        case (code)
            2'h0:    half_period = 8'h02;
            2'h1:    half_period = 8'h08;
            2'h2:    half_period = 8'h20;
            default: half_period = 8'h80;
        endcase
    endfunction : half_period

    // resolve a drive value for push-pull or open-drain pins
    function automatic logic pin_oe(input logic drv, input logic val,
                                    input logic wom);
        pin_oe = drv & (~wom | ~val);
    endfunction : pin_oe

    logic       en;
    logic       mstr;
    logic       cpol;
    logic       cpha;
    logic       wom;
    logic       fden;
    logic       bus_wr;
    logic       bus_rd;
    logic       sck_rise;
    logic       sck_fall;
    logic       ss_low;
    logic       slave_sel;
    logic       lead_edge;
    logic       trail_edge;
    logic       byte_done;
    logic [7:0] rx_byte;

    always_comb begin
        nxt_st = st_ff;
        en   = st_ff.ctrl[`SPSR_C_EN];
        mstr = st_ff.ctrl[`SPSR_C_MSTR];
        cpol = st_ff.ctrl[`SPSR_C_CPOL];
        cpha = st_ff.ctrl[`SPSR_C_CPHA];
        fden = st_ff.stat_cfg[`SPSR_S_FDEN];
        byte_done = 1'b0;
        rx_byte   = st_ff.shift;

        // pins pass two flops before anything looks at them
        nxt_st.sck_sync1  = sck_in;
        nxt_st.sck_sync2  = st_ff.sck_sync1;
        nxt_st.sck_prev   = st_ff.sck_sync2;
        nxt_st.ss_sync1   = ss_n_in;
        nxt_st.ss_sync2   = st_ff.ss_sync1;
        nxt_st.ss_prev    = st_ff.ss_sync2;
        nxt_st.miso_sync1 = miso_in;
        nxt_st.miso_sync2 = st_ff.miso_sync1;
        nxt_st.mosi_sync1 = mosi_in;
        nxt_st.mosi_sync2 = st_ff.mosi_sync1;
        sck_rise = st_ff.sck_sync2 & ~st_ff.sck_prev;
        sck_fall = ~st_ff.sck_sync2 & st_ff.sck_prev;
        ss_low   = ~st_ff.ss_sync2;
        slave_sel = en & ~mstr & ss_low;

        // bus slave: request answered on the second cycle
        bus_wr = avs_write & st_ff.waitreq;
        bus_rd = avs_read & st_ff.waitreq;
        nxt_st.waitreq = ~((avs_read | avs_write) & st_ff.waitreq);
        nxt_st.rdata = 8'h00;
        if (bus_rd) begin
            case (avs_address)
                `SPSR_ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
                `SPSR_ADDR_STAT: begin
                    nxt_st.rdata = st_ff.stat_cfg;
                    nxt_st.rdata[`SPSR_S_RXF]  = st_ff.rx_full;
                    nxt_st.rdata[`SPSR_S_OVR]  = st_ff.overrun;
                    nxt_st.rdata[`SPSR_S_MODE_FAULT_FLAG] = st_ff.mode_fault;
                    nxt_st.rdata[`SPSR_S_TXE]  = st_ff.tx_empty;
                    // first step of the two-step clears
                    nxt_st.rx_armed   = st_ff.rx_full;
                    nxt_st.ovr_armed  = st_ff.overrun;
                    nxt_st.mode_fault_flag_armed = st_ff.mode_fault;
                end
                `SPSR_ADDR_DATA: begin
                    nxt_st.rdata = st_ff.rx_data;
                    if (st_ff.rx_armed) begin
                        nxt_st.rx_full  = 1'b0;
                        nxt_st.rx_armed = 1'b0;
                    end
                    if (st_ff.ovr_armed) begin
                        nxt_st.overrun   = 1'b0;
                        nxt_st.ovr_armed = 1'b0;
                    end
                end
                default: nxt_st.rdata = 8'h00;
            endcase
        end
        if (bus_wr) begin
            case (avs_address)
                `SPSR_ADDR_CTRL: begin
                    nxt_st.ctrl = avs_writedata & `SPSR_CTRL_MASK;
                    if (st_ff.mode_fault_flag_armed) begin
                        nxt_st.mode_fault = 1'b0;
                        nxt_st.mode_fault_flag_armed = 1'b0;
                    end
                end
                `SPSR_ADDR_STAT: begin
                    // flags are read-only; fault flag survives fden clear
                    nxt_st.stat_cfg = avs_writedata & `SPSR_STAT_WMASK;
                end
                `SPSR_ADDR_DATA: begin
                    nxt_st.tx_data  = avs_writedata;
                    nxt_st.tx_empty = 1'b0;
                end
                default: ;
            endcase
        end

        lead_edge  = cpol ? sck_fall : sck_rise;
        trail_edge = cpol ? sck_rise : sck_fall;

        // byte engine
        case (st_ff.phase)
            SPSR_IDLE: begin
                nxt_st.sck_out = cpol;
                if (en && mstr && !st_ff.tx_empty) begin
                    nxt_st.shift    = st_ff.tx_data;
                    nxt_st.tx_empty = 1'b1;
                    nxt_st.bit_cnt  = 4'h0;
                    // start at one: zero marks the cycle after an edge
                    nxt_st.div_cnt  = 8'h01;
                    nxt_st.mosi_out = st_ff.tx_data[7];
                    nxt_st.phase    = SPSR_SHIFT;
                end else if (slave_sel) begin
                    if (!st_ff.tx_empty) begin
                        nxt_st.shift    = st_ff.tx_data;
                        nxt_st.tx_empty = 1'b1;
                    end
                    nxt_st.miso_out = st_ff.tx_empty ? st_ff.shift[7]
                                                     : st_ff.tx_data[7];
                    nxt_st.bit_cnt  = 4'h0;
                    nxt_st.phase    = SPSR_SHIFT;
                end
            end
            SPSR_SHIFT: begin
                if (mstr) begin
                    if (st_ff.div_cnt ==
                        half_period(st_ff.stat_cfg[1:0]) - 8'h01) begin
                        nxt_st.div_cnt = 8'h00;
                        nxt_st.sck_out = ~st_ff.sck_out;
                    end else begin
                        nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
                    end
                    // data moves one clock after each edge, so miso has
                    // passed its synchroniser even at the fastest rate
                    if (st_ff.div_cnt == 8'h00) begin
                        if ((st_ff.sck_out == cpol) ^ cpha) begin
                            nxt_st.mosi_out = st_ff.shift[7];
                        end else begin
                            nxt_st.shift = {st_ff.shift[6:0],
                                            st_ff.miso_sync2};
                            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                        end
                        // end at the eighth return to the idle level
                        if (st_ff.sck_out == cpol &&
                            nxt_st.bit_cnt == `SPSR_BITS_PER_BYTE) begin
                            nxt_st.phase = SPSR_DONE;
                        end
                    end
                end else if (slave_sel) begin
                    if (cpha ? trail_edge : lead_edge) begin
                        nxt_st.shift = {st_ff.shift[6:0],
                                        st_ff.mosi_sync2};
                        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                        if (st_ff.bit_cnt == 4'h7) begin
                            nxt_st.phase = SPSR_DONE;
                        end
                    end else if (cpha ? lead_edge : trail_edge) begin
                        nxt_st.miso_out = st_ff.shift[7];
                    end
                end
            end
            SPSR_DONE: begin
                byte_done    = 1'b1;
                nxt_st.phase = SPSR_IDLE;
                // cpha 0 slave waits for a fresh select before next byte
                if (!mstr && !cpha && ss_low) begin
                    nxt_st.phase = SPSR_DONE;
                    byte_done    = 1'b0;
                end
            end
            default: nxt_st.phase = SPSR_IDLE;
        endcase

        // a clear in the same cycle gives way to the arriving byte
        if (byte_done) begin
            if (nxt_st.rx_full) begin
                nxt_st.overrun = 1'b1;
            end else begin
                nxt_st.rx_data = rx_byte;
                nxt_st.rx_full = 1'b1;
            end
        end

        // mode fault detection
        if (en && fden) begin
            if (mstr && ss_low) begin
                nxt_st.mode_fault   = 1'b1;
                nxt_st.ctrl[`SPSR_C_EN] = 1'b0;
            end else if (!mstr && st_ff.ss_sync2 && !st_ff.ss_prev &&
                         st_ff.phase == SPSR_SHIFT) begin
                nxt_st.mode_fault = 1'b1;
            end
        end

        // partial reset while disabled
        if (!en) begin
            nxt_st.tx_empty = 1'b1;
            nxt_st.phase    = SPSR_IDLE;
            nxt_st.shift    = 8'h00;
            nxt_st.bit_cnt  = 4'h0;
            nxt_st.div_cnt  = 8'h00;
            nxt_st.sck_out  = cpol;
        end

        // pin drivers; next mode so enables and wired_or_mode move together
        wom = nxt_st.ctrl[`SPSR_C_WOM];
        nxt_st.sck_oe  = pin_oe(en & mstr, nxt_st.sck_out, wom);
        nxt_st.mosi_oe = pin_oe(en & mstr, nxt_st.mosi_out, wom);
        nxt_st.miso_oe = pin_oe(slave_sel, nxt_st.miso_out, wom);
        // select pin is port-owned only when disabled, or for a master with fden clear
        nxt_st.ss_gpio = ~en | (mstr & ~fden);

        nxt_st.irq = (st_ff.ctrl[`SPSR_C_RXIE] & st_ff.rx_full) |
                     (st_ff.ctrl[`SPSR_C_TXIE] & en & st_ff.tx_empty) |
                     (st_ff.stat_cfg[`SPSR_S_ERROR_IRQ_ENABLE] &
                      (st_ff.overrun | st_ff.mode_fault));
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff          <= '0;
            st_ff.ctrl     <= `SPSR_CTRL_RST;
            st_ff.tx_empty <= 1'b1;
            st_ff.waitreq  <= 1'b1;
            // released clock pin idles at its pull-up: no false edge
            st_ff.sck_sync1 <= 1'b1;
            st_ff.sck_sync2 <= 1'b1;
            st_ff.sck_prev  <= 1'b1;
            st_ff.ss_sync1 <= 1'b1;
            st_ff.ss_sync2 <= 1'b1;
            st_ff.ss_prev  <= 1'b1;
            st_ff.ss_gpio  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        avs_readdata    = st_ff.rdata;
        avs_waitrequest = st_ff.waitreq;
        sck_out         = st_ff.sck_out;
        sck_oe          = st_ff.sck_oe;
        mosi_out        = st_ff.mosi_out;
        mosi_oe         = st_ff.mosi_oe;
        miso_out        = st_ff.miso_out;
        miso_oe         = st_ff.miso_oe;
        ss_gpio         = st_ff.ss_gpio;
        wired_or_mode   = st_ff.ctrl[`SPSR_C_WOM];
        irq             = st_ff.irq;
    end

endmodule : spsr_core

// ==== hw/spsr_params.svh ====
// Purpose: constants for the serial peripheral select and register block
// Assumes: avalon word addressing, one 8-bit register per word
// Notes:   bit positions follow the control and status register layouts
`ifndef SPSR_PARAMS_SVH
`define SPSR_PARAMS_SVH

`define SPSR_ADDR_CTRL      2'h0
`define SPSR_ADDR_STAT      2'h1
`define SPSR_ADDR_DATA      2'h2

// control register bits
`define SPSR_C_RXIE         7
`define SPSR_C_MSTR         5
`define SPSR_C_CPOL         4
`define SPSR_C_CPHA         3
`define SPSR_C_WOM          2
`define SPSR_C_EN           1
`define SPSR_C_TXIE         0
`define SPSR_CTRL_RST       8'h28
`define SPSR_CTRL_MASK      8'hBF

// status register bits
`define SPSR_S_RXF          7
`define SPSR_S_ERROR_IRQ_ENABLE        6
`define SPSR_S_OVR          5
`define SPSR_S_MODE_FAULT_FLAG         4
`define SPSR_S_TXE          3
`define SPSR_S_FDEN         2
`define SPSR_S_RATE_HI      1
`define SPSR_S_RATE_LO      0
`define SPSR_STAT_WMASK     8'h47

`define SPSR_BITS_PER_BYTE  4'h8

`endif

// ==== hw/spsr_pkg.sv ====
// Purpose: types for the serial peripheral select and register block
// Assumes: constants live in spsr_params.svh
// Notes:   none
package spsr_pkg;

    typedef enum logic [1:0] {
        SPSR_IDLE,
        SPSR_SHIFT,
        SPSR_DONE
    } spsr_phase_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  stat_cfg;
        logic        rx_full;
        logic        overrun;
        logic        mode_fault;
        logic        tx_empty;
        logic        rx_armed;
        logic        ovr_armed;
        logic        mode_fault_flag_armed;
        logic [7:0]  tx_data;
        logic [7:0]  rx_data;
        logic [7:0]  shift;
        logic [3:0]  bit_cnt;
        logic [7:0]  div_cnt;
        spsr_phase_t phase;
        logic        sck_out;
        logic        mosi_out;
        logic        miso_out;
        logic        sck_sync1;
        logic        sck_sync2;
        logic        sck_prev;
        logic        ss_sync1;
        logic        ss_sync2;
        logic        ss_prev;
        logic        miso_sync1;
        logic        miso_sync2;
        logic        mosi_sync1;
        logic        mosi_sync2;
        logic        waitreq;
        logic [7:0]  rdata;
        logic        irq;
        logic        sck_oe;
        logic        mosi_oe;
        logic        miso_oe;
        logic        ss_gpio;
    } spsr_state_t;

endpackage : spsr_pkg

// ==== testbench/spsr_assertions.sv ====
// Purpose: port-level properties of the serial select and register block
// Assumes: single clock domain, rstn active low
// Notes:   bus answer figures follow the one-cycle wait state of this block
`timescale 1ns/1ps
module spsr_assertions (
    input logic       core_clk,
    input logic       rstn,
    input logic [1:0] avs_address,
    input logic       avs_read,
    input logic       avs_write,
    input logic [7:0] avs_writedata,
    input logic [7:0] avs_readdata,
    input logic       avs_waitrequest,
    input logic       sck_out,
    input logic       sck_oe,
    input logic       mosi_out,
    input logic       mosi_oe,
    input logic       miso_out,
    input logic       miso_oe,
    input logic       ss_n_in,
    input logic       ss_gpio,
    input logic       wired_or_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("request not answered next cycle");
    property p_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("answer longer than one cycle");
    property p_unmapped;
        avs_read && avs_waitrequest && avs_address == 2'h3
            |=> avs_readdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_gap;
        avs_read && avs_waitrequest && avs_address == 2'h0
            |=> !avs_readdata[6];
    endproperty
    a_gap: assert property (p_gap)
        else $error("unused control bit reads one");
    property p_wom;
        avs_write && avs_waitrequest && avs_address == 2'h0
            |=> wired_or_mode == $past(avs_writedata[2]);
    endproperty
    a_wom: assert property (p_wom)
        else $error("wired-or output not following control");
    property p_open_drain;
        wired_or_mode |-> !(sck_oe && sck_out) && !(mosi_oe && mosi_out)
            && !(miso_oe && miso_out);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("high level driven in wired-or mode");
    property p_desel;
        ss_n_in [*5] |-> !miso_oe;
    endproperty
    a_desel: assert property (p_desel)
        else $error("miso driven while deselected");
    property p_sck_hold;
        sck_oe && $changed(sck_out) |=> $stable(sck_out);
    endproperty
    a_sck_hold: assert property (p_sck_hold)
        else $error("serial clock half period under two");
    property p_off;
        avs_write && avs_waitrequest && avs_address == 2'h0
            && !avs_writedata[1]
            |-> ##[1:3] (!sck_oe && !mosi_oe && !miso_oe && ss_gpio);
    endproperty
    a_off: assert property (p_off)
        else $error("pins kept after disable");
endmodule : spsr_assertions

// ==== testbench/spsr_peer.sv ====
// Purpose: behavioural far-end slave of the serial link
// Assumes: msb first; leading edge launches a bit, trailing edge samples
// Notes:   released miso toggles every clock so stale data cannot match
`timescale 1ns/1ps
module spsr_peer (
    input  wire logic       clk,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel,
    input  wire logic       cpol,
    input  wire logic [7:0] reply,
    output logic            miso,
    output logic [7:0]      got
);
    logic [7:0] sh = 8'h00;
    logic [7:0] rxs = 8'h00;
    logic [2:0] cnt = 3'h0;
    logic       bit_q = 1'b0;
    logic       tog = 1'b0;
    wire  logic lead = sck ^ cpol;
    initial got = 8'h00;
    always @(posedge clk) tog <= ~tog;
    assign miso = sel ? bit_q : tog;
    // select stays low across bytes, legal with clock phase one
    always @(posedge lead) begin
        if (sel) begin
            if (cnt == 3'h0) sh = reply;
            bit_q <= sh[7];
            sh = {sh[6:0], 1'b0};
        end
    end
    always @(negedge lead) begin
        if (sel) begin
            rxs = {rxs[6:0], mosi};
            if (cnt == 3'h7) got <= rxs;
            cnt <= cnt + 3'h1;
        end
    end
endmodule : spsr_peer

// ==== testbench/tb.sv ====
// Purpose: register and pin level bench of the serial select block
// Assumes: peer slave on the link, pull-ups on released sck and mosi lines
// Notes:   data bytes are bit palindromes so bit order is not assumed
`timescale 1ns/1ps
`include "spsr_params.svh"
module tb;
    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    logic [1:0] avs_address = 2'h0;
    logic       avs_read = 1'b0;
    logic       avs_write = 1'b0;
    logic [7:0] avs_writedata = 8'h00;
    logic       ss_n_in = 1'b1;
    logic       peer_sel = 1'b0;
    logic       peer_cpol = 1'b0;
    logic [7:0] peer_reply = 8'h00;
    logic [7:0] avs_readdata, peer_got;
    logic       avs_waitrequest, sck_out, sck_oe, mosi_out, mosi_oe, irq;
    logic       miso_out, miso_oe, ss_gpio, wired_or_mode, peer_miso;
    int         fail_count = 0;
    int         n_checks = 0;
    int         cyc = 0;
    wire logic  sck_w = sck_oe ? sck_out : 1'b1;
    wire logic  mosi_w = mosi_oe ? mosi_out : 1'b1;
    wire logic  miso_w = miso_oe ? miso_out : peer_miso;
    spsr_core i_spsr_core (.core_clk(core_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
        .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
        .ss_n_in(ss_n_in), .ss_gpio(ss_gpio),
        .wired_or_mode(wired_or_mode), .irq(irq));
    spsr_peer i_spsr_peer (.clk(core_clk), .sck(sck_w), .mosi(mosi_w),
        .sel(peer_sel), .cpol(peer_cpol), .reply(peer_reply),
        .miso(peer_miso), .got(peer_got));
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // request held until waitrequest is sampled low, released after
    task automatic bus(input logic w, input logic [1:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask : rd
    task automatic poll(input int b);
        logic [7:0] q;
        int n = 0;
        do begin
            bus(1'b0, `SPSR_ADDR_STAT, 8'h00, q);
            n++;
        end while (q[b] !== 1'b1 && n < 2000);
    endtask : poll
    task automatic settle();
        repeat (4) @(posedge core_clk);
    endtask : settle
    task automatic wait_edge(output int n);
        logic s;
        n = 0;
        s = sck_w;
        while (sck_w === s && n < 400) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_edge
    initial begin
        int n;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(`SPSR_ADDR_CTRL, 8'h28);
        rd(`SPSR_ADDR_STAT, 8'h08);
        rd(2'h3, 8'h00);
        chk({7'h0, ss_gpio}, 8'h01);
        wr(`SPSR_ADDR_CTRL, 8'hFF);
        wr(`SPSR_ADDR_STAT, 8'hFF);
        settle();
        chk({7'h0, irq}, 8'h01);
        chk({7'h0, wired_or_mode}, 8'h01);
        rd(`SPSR_ADDR_CTRL, 8'hBF);
        rd(`SPSR_ADDR_STAT, 8'h4F);
        wr(`SPSR_ADDR_CTRL, 8'hBE);
        settle();
        chk({7'h0, irq}, 8'h00);
        wr(`SPSR_ADDR_STAT, 8'h00);
        wr(`SPSR_ADDR_CTRL, 8'h08);
        $display("test registers done");
        for (int r = 0; r < 4; r++) begin
            peer_cpol <= r[0];
            peer_reply <= 8'h3C;
            wr(`SPSR_ADDR_STAT, {6'h00, r[1:0]});
            wr(`SPSR_ADDR_CTRL, {3'h1, r[0], 1'b1, r[1], 2'h2});
            settle();
            chk({7'h0, sck_w}, {7'h0, r[0]});
            peer_sel <= 1'b1;
            wr(`SPSR_ADDR_DATA, 8'hA5);
            wait_edge(n);
            wait_edge(n);
            chk(n[7:0], 8'h02 << (2 * r));
            poll(7);
            rd(`SPSR_ADDR_DATA, 8'h3C);
            rd(`SPSR_ADDR_STAT, {6'h02, r[1:0]});
            chk(peer_got, 8'hA5);
            peer_sel <= 1'b0;
        end
        $display("test rates done");
        peer_cpol <= 1'b0;
        peer_reply <= 8'h81;
        wr(`SPSR_ADDR_STAT, 8'h41);
        wr(`SPSR_ADDR_CTRL, 8'h2A);
        peer_sel <= 1'b1;
        wr(`SPSR_ADDR_DATA, 8'h18);
        poll(7);
        settle();
        chk({7'h0, irq}, 8'h00);
        wr(`SPSR_ADDR_CTRL, 8'hAA);
        settle();
        chk({7'h0, irq}, 8'h01);
        wr(`SPSR_ADDR_CTRL, 8'h2A);
        peer_reply <= 8'h66;
        wr(`SPSR_ADDR_DATA, 8'h24);
        poll(5);
        settle();
        chk({7'h0, irq}, 8'h01);
        rd(`SPSR_ADDR_STAT, 8'hE9);
        rd(`SPSR_ADDR_DATA, 8'h81);
        rd(`SPSR_ADDR_STAT, 8'h49);
        settle();
        chk({7'h0, irq}, 8'h00);
        peer_sel <= 1'b0;
        $display("test overrun done");
        wr(`SPSR_ADDR_STAT, 8'h05);
        settle();
        chk({7'h0, ss_gpio}, 8'h00);
        ss_n_in <= 1'b0;
        settle();
        ss_n_in <= 1'b1;
        wr(`SPSR_ADDR_CTRL, 8'h28);
        rd(`SPSR_ADDR_STAT, 8'h1D);
        wr(`SPSR_ADDR_STAT, 8'h01);
        rd(`SPSR_ADDR_STAT, 8'h19);
        wr(`SPSR_ADDR_CTRL, 8'h2A);
        rd(`SPSR_ADDR_STAT, 8'h09);
        ss_n_in <= 1'b0;
        settle();
        chk({7'h0, ss_gpio}, 8'h01);
        rd(`SPSR_ADDR_STAT, 8'h09);
        ss_n_in <= 1'b1;
        $display("test fault done");
        wr(`SPSR_ADDR_CTRL, 8'h0A);
        settle();
        chk({7'h0, ss_gpio}, 8'h00);
        chk({7'h0, miso_oe}, 8'h00);
        wr(`SPSR_ADDR_CTRL, 8'h08);
        settle();
        chk({5'h0, sck_oe, mosi_oe, ss_gpio}, 8'h01);
        rd(`SPSR_ADDR_STAT, 8'h09);
        $display("test pins done");
        finish_test();
    end
endmodule : tb
bind spsr_core spsr_assertions i_spsr_assertions (.core_clk(core_clk),
    .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .ss_n_in(ss_n_in), .ss_gpio(ss_gpio), .wired_or_mode(wired_or_mode));
